// ### ubr_uart.sv
// Contract
// (R1) Software arms break: transmit enable plus send-break.
// (R2) Next holding write starts break, value ignored.
// (R3) Software queues sync character behind the break.
// (R4) Hardware clears send-break, then sends queued sync.
// (R5) Receive interrupt per select field and count.
// (R6) Overrun flag sticks until software clears it.
// (R7) Receive read pops; error flags follow new top.
// (R8) Active-low handshake pins configured by pin field.
// (R9) Simplex and flow-control handshake modes supported.
// (R10) Pin field 11 drives 16x clock on RTS; the code drives the baud generator tick clock, 4x with the high-speed bit set.
// (R11) Mode bit 12 enables infrared codec.
// (R12) Infrared codec sits on receive and transmit pins.
// (R13) Mode bit 13 stops module in idle.
// (R14) Mode bit 11 selects RTS pin mode.
// (R15) RTS mode 1 simplex, 0 flow control.
// (R16) Infrared codec only works at standard speed.
// (R17) Mode bit 15 enables module and pins.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ubr_uart (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin,
  output logic             serial_tx_oe,
  input  wire logic        clear_to_send_n,
  output logic             request_to_send_n,
  output logic             request_to_send_oe,
  input  wire logic        idle_mode,
  output logic             rx_irq
);
  typedef struct packed {
    logic [15:0]            mode;
    logic                   txen;
    logic                   brk;
    logic                   brk_req;
    logic [1:0]             rxsel;
    logic                   overrun_flag;
    logic [15:0]            brg;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    ubr_pkg::ubr_tx_state_t tx_st;
    logic [4:0]             tx_os;
    logic [3:0]             tx_bits;
    logic [13:0]            tx_sh;
    ubr_pkg::ubr_rx_state_t rx_st;
    logic [4:0]             rx_os;
    logic [3:0]             rx_bits;
    logic [9:0]             rx_sh;
    logic [4:0]             ir_cnt;
    logic                   tx_pin;
    logic                   rts_n;
    logic                   oe;
    logic                   rts_oe;
    logic                   irq;
  } ubr_uart_state_t;

  ubr_uart_state_t s_r;
  ubr_uart_state_t s_nxt;

  logic                       os_tick;
  logic                       os_clk;
  logic                       run;
  logic                       brg_restart;
  logic                       flush;
  logic                       tx_push;
  logic                       tx_pop;
  logic [ubr_pkg::FIFO_W-1:0] tx_wdata;
  logic [ubr_pkg::FIFO_W-1:0] tx_head;
  logic                       tx_full;
  logic                       tx_empty;
  logic                       rx_push;
  logic                       rx_pop;
  logic [ubr_pkg::FIFO_W-1:0] rx_wdata;
  logic [ubr_pkg::FIFO_W-1:0] rx_head;
  logic                       rx_full;
  logic                       rx_empty;
  logic [2:0]                 rx_count;
  logic                       wr_take;
  logic                       rd_take;

  // Character frame, least significant bit first: start, data, parity, stop bits.
  function automatic logic [13:0] tx_frame(input logic [8:0] d, input logic [1:0] pd);
    logic [13:0] f;
    f      = 14'h3fff;
    f[0]   = 1'b0;
    f[8:1] = d[7:0];
    case (pd)
      ubr_pkg::PD_9BIT: f[9] = d[8];
      ubr_pkg::PD_EVEN: f[9] = ^d[7:0];
      ubr_pkg::PD_ODD:  f[9] = ~^d[7:0];
      default:          f[9] = 1'b1;
    endcase
    return f;
  endfunction

  // Returns framing error, parity error and nine data bits from the receive shifter.
  function automatic logic [10:0] rx_unpack(input logic [9:0] sh, input logic [1:0] pd,
                                            input logic fe);
    logic [10:0] r;
    case (pd)
      ubr_pkg::PD_9BIT: r = {fe, 1'b0, sh[9:1]};
      ubr_pkg::PD_EVEN: r = {fe, ^sh[9:1], 1'b0, sh[8:1]};
      ubr_pkg::PD_ODD:  r = {fe, ~^sh[9:1], 1'b0, sh[8:1]};
      default:          r = {fe, 1'b0, 1'b0, sh[9:2]};
    endcase
    return r;
  endfunction

  assign wr_take = awvalid && wvalid && !s_r.bvalid;
  assign rd_take = arvalid && !s_r.rvalid;
  assign awready = wr_take;
  assign wready  = wr_take;
  assign arready = !s_r.rvalid;

  always_comb begin
    logic       en;
    logic       ir_en;
    logic       tx_line;
    logic       rx_line;
    logic [4:0] osn;
    logic [1:0] pd;
    logic [1:0] uen;
    s_nxt       = s_r;
    tx_push     = 1'b0;
    tx_pop      = 1'b0;
    tx_wdata    = '0;
    rx_push     = 1'b0;
    rx_pop      = 1'b0;
    rx_wdata    = '0;
    brg_restart = 1'b0;
    en          = s_r.mode[ubr_pkg::MODE_EN]; // R17
    pd          = s_r.mode[ubr_pkg::MODE_PD +: 2];
    uen         = s_r.mode[ubr_pkg::MODE_UEN +: 2];
    osn         = s_r.mode[ubr_pkg::MODE_HIGH_SPEED_BAUD_BIT] ? ubr_pkg::OS_HS : ubr_pkg::OS_STD;
    ir_en       = s_r.mode[ubr_pkg::MODE_IR] && !s_r.mode[ubr_pkg::MODE_HIGH_SPEED_BAUD_BIT]; // R11 R16
    run         = en && !(s_r.mode[ubr_pkg::MODE_IDLE] && idle_mode); // R13
    flush       = !en;
    tx_line     = (s_r.tx_st == ubr_pkg::TX_IDLE) || s_r.tx_sh[0];
    rx_line     = 1'b1;

    // Transmitter, placed ahead of the bus so a software set of send-break wins.
    case (s_r.tx_st)
      ubr_pkg::TX_IDLE: begin
        s_nxt.tx_os = 5'h00;
        if (run && s_r.txen && s_r.brk_req) begin
          s_nxt.tx_st   = ubr_pkg::TX_BREAK; // R2
          s_nxt.tx_sh   = ubr_pkg::BRK_FRAME;
          s_nxt.tx_bits = ubr_pkg::BRK_LEN;
        end else if (run && s_r.txen && !tx_empty && !s_r.brk_req &&
                     !(uen == ubr_pkg::UEN_FLOW && clear_to_send_n)) begin // R9
          tx_pop        = 1'b1;
          s_nxt.tx_st   = ubr_pkg::TX_SHIFT;
          s_nxt.tx_sh   = tx_frame(tx_head[8:0], pd);
          s_nxt.tx_bits = 4'ha + {3'h0, pd != ubr_pkg::PD_NONE}
                          + {3'h0, s_r.mode[ubr_pkg::MODE_STOP_BITS_SELECT]};
        end
      end
      ubr_pkg::TX_BREAK, ubr_pkg::TX_SHIFT: begin
        if (os_tick) begin
          if (s_r.tx_os == osn - 5'h01) begin
            s_nxt.tx_os   = 5'h00;
            s_nxt.tx_sh   = {1'b1, s_r.tx_sh[13:1]};
            s_nxt.tx_bits = s_r.tx_bits - 4'h1;
            if (s_r.tx_bits == 4'h1) begin
              s_nxt.tx_st = ubr_pkg::TX_IDLE;
              if (s_r.tx_st == ubr_pkg::TX_BREAK) begin
                s_nxt.brk     = 1'b0; // R4
                s_nxt.brk_req = 1'b0; // R4
              end
            end
          end else begin
            s_nxt.tx_os = s_r.tx_os + 5'h01;
          end
        end
      end
      default: s_nxt.tx_st = ubr_pkg::TX_IDLE;
    endcase

    // Bus writes.
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_take) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = ubr_pkg::RESP_OKAY;
      case (awaddr)
        ubr_pkg::ADDR_MODE: begin
          if (wstrb[0]) s_nxt.mode[7:0] = wdata[7:0] & ubr_pkg::MODE_MASK[7:0];
          if (wstrb[1]) s_nxt.mode[15:8] = wdata[15:8] & ubr_pkg::MODE_MASK[15:8];
        end
        ubr_pkg::ADDR_STAT: begin
          if (wstrb[0]) begin
            s_nxt.txen  = wdata[ubr_pkg::STAT_TXEN];
            s_nxt.rxsel = wdata[ubr_pkg::STAT_RXSEL +: 2];
            if (wdata[ubr_pkg::STAT_BRK]) s_nxt.brk = 1'b1; // R1
            if (!wdata[ubr_pkg::STAT_OVERRUN_FLAG]) s_nxt.overrun_flag = 1'b0; // R6
          end
        end
        ubr_pkg::ADDR_TX: begin
          if (wstrb[0] && en) begin
            if (s_r.brk && !s_r.brk_req) begin
              s_nxt.brk_req = 1'b1; // R2
            end else begin
              tx_push  = 1'b1; // R3
              tx_wdata = {2'h0, wdata[8:0]};
            end
          end
        end
        ubr_pkg::ADDR_BRG: begin
          brg_restart = 1'b1;
          if (wstrb[0]) s_nxt.brg[7:0] = wdata[7:0];
          if (wstrb[1]) s_nxt.brg[15:8] = wdata[15:8];
        end
        default: s_nxt.bresp = ubr_pkg::RESP_SLVERR;
      endcase
    end

    // Bus reads.
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_take) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = ubr_pkg::RESP_OKAY;
      s_nxt.rdata  = 32'h0000_0000;
      case (araddr)
        ubr_pkg::ADDR_MODE: s_nxt.rdata[15:0] = s_r.mode;
        ubr_pkg::ADDR_STAT: begin
          s_nxt.rdata[ubr_pkg::STAT_TXEN]       = s_r.txen;
          s_nxt.rdata[ubr_pkg::STAT_BRK]        = s_r.brk;
          s_nxt.rdata[ubr_pkg::STAT_RXSEL +: 2] = s_r.rxsel;
          s_nxt.rdata[ubr_pkg::STAT_OVERRUN_FLAG]       = s_r.overrun_flag; // R6
          s_nxt.rdata[ubr_pkg::STAT_PARITY_ERR_FLAG]       = !rx_empty && rx_head[9]; // R7
          s_nxt.rdata[ubr_pkg::STAT_FRAMING_ERR_FLAG]       = !rx_empty && rx_head[10]; // R7
          s_nxt.rdata[ubr_pkg::STAT_RXAV]       = !rx_empty;
          s_nxt.rdata[ubr_pkg::STAT_TXFULL]     = tx_full;
          s_nxt.rdata[ubr_pkg::STAT_TXIDLE]     = tx_empty && (s_r.tx_st == ubr_pkg::TX_IDLE);
        end
        ubr_pkg::ADDR_RX: begin
          s_nxt.rdata[8:0] = rx_head[8:0];
          rx_pop           = !rx_empty; // R7
        end
        ubr_pkg::ADDR_TX:  s_nxt.rdata = '0;
        ubr_pkg::ADDR_BRG: s_nxt.rdata[15:0] = s_r.brg;
        default: s_nxt.rresp = ubr_pkg::RESP_SLVERR;
      endcase
    end

    // Infrared decoder stretches each received pulse over one bit time.
    if (ir_en && serial_rx_pin) begin
      s_nxt.ir_cnt = osn; // R12
    end else if (os_tick && s_r.ir_cnt != 5'h00) begin
      s_nxt.ir_cnt = s_r.ir_cnt - 5'h01;
    end
    if (s_r.mode[ubr_pkg::MODE_LPBK]) begin
      rx_line = tx_line;
    end else begin
      rx_line = (ir_en ? (s_r.ir_cnt == 5'h00) : serial_rx_pin)
                ^ s_r.mode[ubr_pkg::MODE_RXINV]; // R12
    end

    // Receiver samples each bit at its middle.
    if (run && os_tick) begin
      case (s_r.rx_st)
        ubr_pkg::RX_IDLE: begin
          s_nxt.rx_os = 5'h00;
          if (!rx_line) s_nxt.rx_st = ubr_pkg::RX_START;
        end
        ubr_pkg::RX_START: begin
          s_nxt.rx_os = s_r.rx_os + 5'h01;
          if (s_r.rx_os == (osn >> 1) - 5'h01) begin
            s_nxt.rx_os   = 5'h00;
            s_nxt.rx_bits = 4'h8 + {3'h0, pd != ubr_pkg::PD_NONE};
            s_nxt.rx_st   = rx_line ? ubr_pkg::RX_IDLE : ubr_pkg::RX_DATA;
          end
        end
        ubr_pkg::RX_DATA, ubr_pkg::RX_STOP: begin
          s_nxt.rx_os = s_r.rx_os + 5'h01;
          if (s_r.rx_os == osn - 5'h01) begin
            s_nxt.rx_os = 5'h00;
            if (s_r.rx_st == ubr_pkg::RX_DATA) begin
              s_nxt.rx_sh   = {rx_line, s_r.rx_sh[9:1]};
              s_nxt.rx_bits = s_r.rx_bits - 4'h1;
              if (s_r.rx_bits == 4'h1) s_nxt.rx_st = ubr_pkg::RX_STOP;
            end else begin
              s_nxt.rx_st = ubr_pkg::RX_IDLE;
              rx_wdata    = rx_unpack(s_r.rx_sh, pd, !rx_line);
              rx_push     = !rx_full;
              if (rx_full) s_nxt.overrun_flag = 1'b1; // R6
            end
          end
        end
        default: s_nxt.rx_st = ubr_pkg::RX_IDLE;
      endcase
    end

    // A disabled module drops its character state and hands its pins back.
    if (!en) begin
      s_nxt.tx_st   = ubr_pkg::TX_IDLE;
      s_nxt.rx_st   = ubr_pkg::RX_IDLE;
      s_nxt.brk_req = 1'b0; // R17
    end

    // Pins are registered, so each follows its cause by one clock.
    s_nxt.oe     = en; // R17
    s_nxt.rts_oe = en && (uen != ubr_pkg::UEN_TXRX); // R8
    if (!en) begin
      s_nxt.tx_pin = 1'b1;
    end else if (ir_en) begin
      s_nxt.tx_pin = !tx_line && (s_r.tx_os < ubr_pkg::IR_PULSE); // R12
    end else begin
      s_nxt.tx_pin = tx_line;
    end
    if (uen == ubr_pkg::UEN_BCLK) begin
      s_nxt.rts_n = os_clk; // R10
    end else if (s_r.mode[ubr_pkg::MODE_RTS_MODE_SELECT]) begin
      s_nxt.rts_n = tx_empty && (s_r.tx_st == ubr_pkg::TX_IDLE); // R14 R15
    end else begin
      s_nxt.rts_n = rx_full; // R15
    end
    case (s_r.rxsel)
      2'h2:    s_nxt.irq = rx_count >= 3'h3; // R5
      2'h3:    s_nxt.irq = rx_full; // R5
      default: s_nxt.irq = !rx_empty; // R5
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r        <= '0;
      s_r.mode   <= ubr_pkg::MODE_RESET;
      s_r.brg    <= ubr_pkg::BRG_RESET;
      s_r.tx_pin <= 1'b1;
      s_r.rts_n  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ubr_baud u_baud (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .run       (run),
    .restart   (brg_restart),
    .brg_value (s_r.brg),
    .os_tick   (os_tick),
    .os_clk    (os_clk)
  );

  ubr_fifo u_tx_fifo (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .flush   (flush),
    .push    (tx_push),
    .wdata   (tx_wdata),
    .pop     (tx_pop),
    .rdata   (tx_head),
    .full    (tx_full),
    .empty   (tx_empty),
    .count   ()
  );

  ubr_fifo u_rx_fifo (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .flush   (flush),
    .push    (rx_push),
    .wdata   (rx_wdata),
    .pop     (rx_pop),
    .rdata   (rx_head),
    .full    (rx_full),
    .empty   (rx_empty),
    .count   (rx_count)
  );

  assign bvalid             = s_r.bvalid;
  assign bresp              = s_r.bresp;
  assign rvalid             = s_r.rvalid;
  assign rresp              = s_r.rresp;
  assign rdata              = s_r.rdata;
  assign serial_tx_pin      = s_r.tx_pin;
  assign serial_tx_oe       = s_r.oe;
  assign request_to_send_n  = s_r.rts_n;
  assign request_to_send_oe = s_r.rts_oe;
  assign rx_irq             = s_r.irq;
endmodule // ubr_uart

// ### ubr_pkg.sv
package ubr_pkg;

  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_TX   = 8'h08;
  localparam logic [7:0] ADDR_RX   = 8'h0c;
  localparam logic [7:0] ADDR_BRG  = 8'h10;

  // Mode register fields.
  localparam int MODE_EN     = 15;
  localparam int MODE_IDLE   = 13;
  localparam int MODE_IR     = 12;
  localparam int MODE_RTS_MODE_SELECT  = 11;
  localparam int MODE_UEN    = 8;
  localparam int MODE_LPBK   = 6;
  localparam int MODE_AUTO_BAUD_BIT  = 5;
  localparam int MODE_RXINV  = 4;
  localparam int MODE_HIGH_SPEED_BAUD_BIT   = 3;
  localparam int MODE_PD     = 1;
  localparam int MODE_STOP_BITS_SELECT  = 0;
  localparam logic [15:0] MODE_MASK  = 16'hbbff;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] BRG_RESET  = 16'h0000;

  // Status register fields.
  localparam int STAT_TXEN   = 0;
  localparam int STAT_BRK    = 1;
  localparam int STAT_RXSEL  = 2;
  localparam int STAT_OVERRUN_FLAG   = 4;
  localparam int STAT_PARITY_ERR_FLAG   = 5;
  localparam int STAT_FRAMING_ERR_FLAG   = 6;
  localparam int STAT_RXAV   = 7;
  localparam int STAT_TXFULL = 8;
  localparam int STAT_TXIDLE = 9;

  // Pin enable field codes.
  localparam logic [1:0] UEN_TXRX = 2'h0;
  localparam logic [1:0] UEN_RTS  = 2'h1;
  localparam logic [1:0] UEN_FLOW = 2'h2;
  localparam logic [1:0] UEN_BCLK = 2'h3;

  // Parity and data select codes.
  localparam logic [1:0] PD_NONE = 2'h0;
  localparam logic [1:0] PD_EVEN = 2'h1;
  localparam logic [1:0] PD_ODD  = 2'h2;
  localparam logic [1:0] PD_9BIT = 2'h3;

  // Timing counts in baud generator ticks or bit times, the break frame pattern and the FIFO word width.
  localparam logic [4:0]  OS_STD    = 5'h10;
  localparam logic [4:0]  OS_HS     = 5'h04;
  localparam logic [4:0]  IR_PULSE  = 5'h03;
  localparam logic [3:0]  BRK_LEN   = 4'he;
  localparam logic [13:0] BRK_FRAME = 14'h2000;
  localparam int          FIFO_W    = 11;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {TX_IDLE, TX_BREAK, TX_SHIFT} ubr_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubr_rx_state_t;

endpackage

// ### ubr_baud.sv
`timescale 1ns/1ps
module ubr_baud (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic [15:0] brg_value,
  output logic             os_tick,
  output logic             os_clk
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
    logic        clk;
  } ubr_baud_state_t;

  ubr_baud_state_t s_r;
  ubr_baud_state_t s_nxt;

  // Writing the divisor restarts the count so a new rate takes effect at once.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (!run || restart) begin
      s_nxt.cnt = 16'h0000;
    end else if (s_r.cnt == brg_value) begin
      s_nxt.cnt  = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    s_nxt.clk = run && (s_nxt.cnt <= (brg_value >> 1));
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign os_tick = s_r.tick;
  assign os_clk  = s_r.clk;
endmodule // ubr_baud

// ### ubr_fifo.sv
`timescale 1ns/1ps
module ubr_fifo (
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  input  wire logic                       flush,
  input  wire logic                       push,
  input  wire logic [ubr_pkg::FIFO_W-1:0] wdata,
  input  wire logic                       pop,
  output logic      [ubr_pkg::FIFO_W-1:0] rdata,
  output logic                            full,
  output logic                            empty,
  output logic      [2:0]                 count
);
  typedef struct packed {
    logic [3:0][ubr_pkg::FIFO_W-1:0] mem;
    logic [1:0]                      wp;
    logic [1:0]                      rp;
    logic [2:0]                      cnt;
    logic [ubr_pkg::FIFO_W-1:0]      head;
  } ubr_fifo_state_t;

  ubr_fifo_state_t s_r;
  ubr_fifo_state_t s_nxt;

  // The head word is registered from the next state so it always shows the top entry.
  always_comb begin
    logic do_push;
    logic do_pop;
    s_nxt   = s_r;
    do_push = push && (s_r.cnt != 3'h4);
    do_pop  = pop && (s_r.cnt != 3'h0);
    if (do_push) begin
      s_nxt.mem[s_r.wp] = wdata;
      s_nxt.wp          = s_r.wp + 2'h1;
    end
    if (do_pop) begin
      s_nxt.rp = s_r.rp + 2'h1;
    end
    s_nxt.cnt = s_r.cnt + {2'h0, do_push} - {2'h0, do_pop};
    if (flush) begin
      s_nxt.wp  = 2'h0;
      s_nxt.rp  = 2'h0;
      s_nxt.cnt = 3'h0;
    end
    s_nxt.head = s_nxt.mem[s_nxt.rp];
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.head;
  assign full  = (s_r.cnt == 3'h4);
  assign empty = (s_r.cnt == 3'h0);
  assign count = s_r.cnt;
endmodule // ubr_fifo

// ### ubr_monitor.sv
`timescale 1ns/1ps
module ubr_monitor (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        awvalid,
  input wire logic        wvalid,
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        serial_tx_oe,
  input wire logic        request_to_send_oe
);
  default clocking mon_cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_write_answer: assert property (awvalid && wvalid && awready |=> bvalid)
    else $error("write not answered");
  a_write_gate: assert property (awready == (awvalid && wvalid && !bvalid))
    else $error("write ready wrong");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_bresp_done: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_rdata_done: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");
  a_pin_enable: assert property (!serial_tx_oe |-> !request_to_send_oe)
    else $error("handshake pin driven while off");
endmodule // ubr_monitor

bind ubr_uart ubr_monitor u_mon (.ref_clk, .reset_n, .awvalid, .wvalid, .awready, .bvalid,
  .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .serial_tx_oe,
  .request_to_send_oe);

// ### ubr_peer.sv
`timescale 1ns/1ps
module ubr_peer (
  input  wire logic ref_clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  initial rx_line = 1'b1;
  // Sixteen clocks a bit; an idle slot ends each frame so frames never abut.
  task automatic send(input logic [7:0] v, input logic stp);
    logic [10:0] f;
    f = {1'b1, stp, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (16) @(posedge ref_clk);
    end
  endtask
  task automatic get(output logic [7:0] v);
    int k;
    for (k = 0; k < 3000 && tx_line; k++) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    for (k = 0; k < 8; k++) begin
      repeat (16) @(posedge ref_clk);
      v[k] = tx_line;
    end
  endtask
endmodule // ubr_peer

// ### tb_uart_break_rx_flow_infrared.sv
`timescale 1ns/1ps
module tb_uart_break_rx_flow_infrared;
  typedef struct packed {
    logic [7:0]  a;
    logic [15:0] w;
    logic [15:0] r;
    logic [1:0]  s;
  } ubr_row_t;
  logic        ref_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, serial_rx_pin, serial_tx_pin, serial_tx_oe;
  logic        clear_to_send_n, request_to_send_n, request_to_send_oe, idle_mode, rx_irq;
  logic [7:0]  awaddr, araddr, b;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          errors, comparisons, n;
  ubr_row_t    rows [5];
  wire  [3:0]  hsv = {rvalid, arready, bvalid, awready};

  ubr_uart u_dut (.ref_clk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .serial_rx_pin, .serial_tx_pin, .serial_tx_oe, .clear_to_send_n,
    .request_to_send_n, .request_to_send_oe, .idle_mode, .rx_irq);
  ubr_peer u_peer (.ref_clk(ref_clk), .tx_line(serial_tx_pin), .rx_line(serial_rx_pin));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    test_done();
  end

  task automatic test_done();
    $display("counts: errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      errors++;
    end
  endtask
  // Tolerance covers where the first divider tick lands against the request.
  task automatic near(input int g, input int e);
    chk((g >= e - 2 && g <= e + 2) ? e : g, e);
  endtask
  task automatic lim(input int k, input int m);
    if (k >= m) begin
      errors++;
      test_done();
    end
  endtask
  task automatic hs(input int w);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (hsv[w] !== 1'b1 && k < 99);
    @(posedge ref_clk);
    lim(k, 99);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] s);
    awaddr <= a;
    wdata <= {16'h0000, v};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    hs(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    hs(1);
    s = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    araddr <= a;
    arvalid <= 1'b1;
    hs(2);
    arvalid <= 1'b0;
    hs(3);
    v = rdata;
    s = rresp;
  endtask
  task automatic run(input logic v, output int c);
    int k;
    for (k = 0; k < 2000 && serial_tx_pin !== v; k++) @(negedge ref_clk);
    for (c = 0; c < 2000 && serial_tx_pin === v; c++) @(negedge ref_clk);
    lim(k, 2000);
    lim(c, 2000);
  endtask

  initial begin
    reset_n = 1'b0;
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, arvalid} = '0;
    {bready, rready, clear_to_send_n, idle_mode, errors, comparisons} = '0;
    bready = 1'b1;
    rready = 1'b1;
    rows = '{'{ubr_pkg::ADDR_TX, 16'h00aa, 16'h0000, ubr_pkg::RESP_OKAY},
             '{ubr_pkg::ADDR_MODE, 16'hffff, 16'hbbff, ubr_pkg::RESP_OKAY},
             '{ubr_pkg::ADDR_MODE, 16'h0000, 16'h0000, ubr_pkg::RESP_OKAY},
             '{ubr_pkg::ADDR_BRG, 16'h0003, 16'h0003, ubr_pkg::RESP_OKAY},
             '{8'h14, 16'h1234, 16'h0000, ubr_pkg::RESP_SLVERR}};
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk(serial_tx_oe, 1'b0);
    chk(request_to_send_n, 1'b1);
    rd(ubr_pkg::ADDR_MODE, d, r);
    chk(d, ubr_pkg::MODE_RESET);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, r);
      chk(r, rows[i].s);
      rd(rows[i].a, d, r);
      chk(d, rows[i].r);
      chk(r, rows[i].s);
    end
    $display("reset and register tests end");
    wr(ubr_pkg::ADDR_BRG, 16'h0000, r);
    wr(ubr_pkg::ADDR_MODE, 16'h8000, r);
    wr(ubr_pkg::ADDR_STAT, 16'h0003, r);
    fork
      run(1'b0, n);
      begin
        wr(ubr_pkg::ADDR_TX, 16'h00ff, r);
        wr(ubr_pkg::ADDR_TX, 16'h0055, r);
      end
    join
    near(n, 208);
    u_peer.get(b);
    chk(b, 8'h55);
    rd(ubr_pkg::ADDR_STAT, d, r);
    chk(d[ubr_pkg::STAT_BRK], 1'b0);
    $display("break test end");
    u_peer.send(8'h11, 1'b1);
    u_peer.send(8'h22, 1'b0);
    repeat (24) @(posedge ref_clk);
    chk(rx_irq, 1'b1);
    rd(ubr_pkg::ADDR_STAT, d, r);
    chk(d[ubr_pkg::STAT_FRAMING_ERR_FLAG], 1'b0);
    rd(ubr_pkg::ADDR_RX, d, r);
    chk(d, 32'h0000_0011);
    rd(ubr_pkg::ADDR_STAT, d, r);
    chk(d[ubr_pkg::STAT_FRAMING_ERR_FLAG], 1'b1);
    rd(ubr_pkg::ADDR_RX, d, r);
    chk(d, 32'h0000_0022);
    wr(ubr_pkg::ADDR_MODE, 16'h8100, r);
    for (int i = 0; i < 5; i++) begin
      u_peer.send(8'(i), 1'b1);
    end
    repeat (24) @(posedge ref_clk);
    chk(request_to_send_n, 1'b1);
    chk(request_to_send_oe, 1'b1);
    wr(ubr_pkg::ADDR_STAT, 16'h0011, r);
    rd(ubr_pkg::ADDR_STAT, d, r);
    chk(d[ubr_pkg::STAT_OVERRUN_FLAG], 1'b1);
    wr(ubr_pkg::ADDR_STAT, 16'h0001, r);
    rd(ubr_pkg::ADDR_STAT, d, r);
    chk(d[ubr_pkg::STAT_OVERRUN_FLAG], 1'b0);
    rd(ubr_pkg::ADDR_RX, d, r);
    repeat (2) @(posedge ref_clk);
    chk(request_to_send_n, 1'b0);
    $display("receive and flow tests end");
    wr(ubr_pkg::ADDR_MODE, 16'h8900, r);
    wr(ubr_pkg::ADDR_TX, 16'h0000, r);
    repeat (20) @(posedge ref_clk);
    chk(request_to_send_n, 1'b0);
    repeat (200) @(posedge ref_clk);
    chk(request_to_send_n, 1'b1);
    wr(ubr_pkg::ADDR_BRG, 16'h0003, r);
    wr(ubr_pkg::ADDR_MODE, 16'h8300, r);
    n = 0;
    for (int i = 0; i < 32; i++) begin
      @(posedge ref_clk);
      n += (request_to_send_n === 1'b0);
    end
    chk(n, 16);
    $display("handshake pin tests end");
    wr(ubr_pkg::ADDR_BRG, 16'h0000, r);
    wr(ubr_pkg::ADDR_MODE, 16'h9000, r);
    repeat (4) @(posedge ref_clk);
    chk(serial_tx_pin, 1'b0);
    fork
      run(1'b1, n);
      wr(ubr_pkg::ADDR_TX, 16'h0000, r);
    join
    chk(n, ubr_pkg::IR_PULSE);
    repeat (200) @(posedge ref_clk);
    wr(ubr_pkg::ADDR_MODE, 16'hb008, r);
    idle_mode <= 1'b1;
    wr(ubr_pkg::ADDR_TX, 16'h0000, r);
    repeat (300) @(posedge ref_clk);
    chk(serial_tx_pin, 1'b1);
    idle_mode <= 1'b0;
    run(1'b0, n);
    near(n, 36);
    wr(ubr_pkg::ADDR_MODE, 16'h0000, r);
    repeat (2) @(posedge ref_clk);
    chk(serial_tx_oe, 1'b0);
    chk(request_to_send_oe, 1'b0);
    $display("infrared, idle and disable tests end");
    test_done();
  end
endmodule // tb_uart_break_rx_flow_infrared
